/* File: rtl/dci_cmd_if.sv */
// command, clocking and power-state interface of an eight-bank ddr sdram
// Behaviour
// - bursts of four or eight, programmed length
// - activate takes bank and 14/15-bit row
// - column bits 0-9, bit 10 auto precharge
// - read column latency three to seven
// - posted extra latency zero to six added
// - write latency one less than read
// - eight independent concurrently usable banks
// - two words per clock, four-word fetch
// - inputs sampled on rising true clock
// - read words on both clock crossings
// - delay-locked loop aligns output data
// - clock gating low stops internal activity
// - gating synchronous except self-refresh exit
// - power-down keeps clocks, termination, gating inputs
// - self refresh keeps only gating input
// - rank select high masks the command
// - command decoded from strobes and select
// - precharge bit 10 selects one or all
// - mode set: bank picks register, address opcode
// - masked write words are discarded
//
// Design decisions made here: the address map and the APB slave port.
module dci_cmd_if (
  input wire logic clock,
  input wire logic sys_rst,
  input wire dci_pkg::dci_apb_req_t apb_req,
  output dci_pkg::dci_apb_rsp_t apb_rsp,
  input wire dci_pkg::dci_cmd_pins_t cmd_pins,
  input wire logic termination_enable,
  input wire dci_pkg::dci_wr_data_t wr_data,
  output dci_pkg::dci_rd_data_t rd_data,
  output logic dll_locked,
  output logic odt_active
);

  // ==========================================================
  // state and storage
  dci_pkg::dci_state_t s; // all control state
  dci_pkg::dci_state_t next_s; // its next value
  logic [dci_pkg::DQ_W-1:0] mem [0:dci_pkg::MEM_DEPTH-1]; // data array, low columns only

  // ==========================================================
  // command decode
  logic [3:0] cmd_code; // strobes with rank select
  logic cmd_live; // inputs are listened to this cycle
  logic is_act;
  logic is_rd;
  logic is_wr;
  logic is_pre;
  logic is_mrs;
  logic is_ref;
  logic [dci_pkg::NBANK-1:0] row_open; // open flags of all banks
  logic [dci_pkg::NBANK-1:0] bank_act; // activate per bank
  logic [dci_pkg::NBANK-1:0] bank_pre; // precharge per bank
  logic [dci_pkg::ADDR_W-1:0] row_in; // row trimmed to part width
  logic all_idle; // no bank holds an open row
  logic col_ok; // column command accepted
  logic beat_now; // a data beat happens at this edge
  logic [1:0] last_beat; // final beat index of the burst
  logic bst_end; // last beat happens at this edge
  logic wr_beat; // write words land in the array
  logic [2:0] blm; // wrap mask for the burst
  logic [3:0] rl_m1; // total read latency minus one
  logic [7:0] widx [0:3]; // array index of the four fetched words

  assign cmd_code = {cmd_pins.cs_n, cmd_pins.ras_n, cmd_pins.cas_n, cmd_pins.we_n};
  // inputs count only while awake and gated on, except refresh, which is decoded with gating low too; cs_n high never matches a code
  assign cmd_live = (s.pwr == dci_pkg::PWR_ACTIVE) && cmd_pins.cke;
  assign is_act = cmd_live && (cmd_code == dci_pkg::CMD_ACT);
  assign is_rd = cmd_live && (cmd_code == dci_pkg::CMD_RD);
  assign is_wr = cmd_live && (cmd_code == dci_pkg::CMD_WR);
  assign is_pre = cmd_live && (cmd_code == dci_pkg::CMD_PRE);
  assign is_mrs = cmd_live && (cmd_code == dci_pkg::CMD_MRS);
  assign is_ref = (cmd_code == dci_pkg::CMD_REF);
  assign all_idle = (row_open == '0);
  // the x16 part has one row bit fewer
  assign row_in = s.x16 ? {1'b0, cmd_pins.addr[13:0]} : cmd_pins.addr;
  // only one burst in flight; a column command during one is dropped
  assign col_ok = (is_rd || is_wr) && !s.bst_act && row_open[cmd_pins.bank_sel];
  assign blm = s.bl8 ? 3'h7 : 3'h3;
  assign last_beat = s.bl8 ? 2'h3 : 2'h1;
  assign beat_now = s.bst_act && (s.bst_wait == 4'h0) && cmd_pins.cke;
  assign bst_end = beat_now && (s.bst_beat == last_beat);
  assign wr_beat = beat_now && s.bst_wr;
  assign rl_m1 = {1'b0, s.al} + {1'b0, s.cl} - 4'h1;

  // ==========================================================
  // per-bank trackers and fetch addressing
  genvar gi;
  generate
    for (gi = 0; gi < dci_pkg::NBANK; gi++) begin : g_bank
      // auto precharge closes the bank after its last beat
      assign bank_act[gi] = is_act && (cmd_pins.bank_sel == 3'(gi));
      assign bank_pre[gi] = (is_pre && (cmd_pins.addr[10] || (cmd_pins.bank_sel == 3'(gi))))
        || (bst_end && s.bst_ap && (s.bst_bank == 3'(gi)));
      dci_bank u_bank (
        .clock(clock),
        .sys_rst(sys_rst),
        .act_hit(bank_act[gi]),
        .pre_hit(bank_pre[gi]),
        .row_in(row_in),
        .row_open(row_open[gi]),
        .open_row()
      );
    end
    // sequential order from the start column, wrapping inside the burst
    for (gi = 0; gi < 4; gi++) begin : g_word
      assign widx[gi] = {s.bst_bank, (s.bst_col[4:0] & ~{2'b00, blm})
        | {2'b00, (s.bst_col[2:0] + {s.bst_beat, 1'b0} + 3'(gi)) & blm}};
    end
  endgenerate

  // ==========================================================
  // data array write port: two words per beat
  always_ff @(posedge clock) begin
    if (wr_beat) begin
      if (!wr_data.write_mask[0]) begin
        mem[widx[0]] <= wr_data.wr_word_rise;
      end
      if (!wr_data.write_mask[1]) begin
        mem[widx[1]] <= wr_data.wr_word_fall;
      end
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    // ---- apb slave: ready one cycle after setup, zero wait in access
    next_s.apb.pready = apb_req.psel && !apb_req.penable;
    // error flag lives only beside pready, so it never lingers after a refused access
    next_s.apb.pslverr = 1'b0;
    if (apb_req.psel && !apb_req.penable) begin
      next_s.apb.prdata = '0;
      case (apb_req.paddr)
        dci_pkg::REG_CONFIG: begin
          next_s.apb.prdata[dci_pkg::CFG_CL_LSB +: 3] = s.cl;
          next_s.apb.prdata[dci_pkg::CFG_AL_LSB +: 3] = s.al;
          next_s.apb.prdata[dci_pkg::CFG_BL8_BIT] = s.bl8;
          next_s.apb.prdata[dci_pkg::CFG_X16_BIT] = s.x16;
        end
        dci_pkg::REG_STATUS: begin
          next_s.apb.prdata[dci_pkg::STAT_OPEN_LSB +: 8] = row_open;
          next_s.apb.prdata[dci_pkg::STAT_PWR_LSB +: 2] = s.pwr;
          next_s.apb.prdata[dci_pkg::STAT_DLL_BIT] = s.dll_locked;
          next_s.apb.prdata[dci_pkg::STAT_ERR_CLOSED_BIT] = s.err_closed;
          next_s.apb.prdata[dci_pkg::STAT_ERR_CKE_BIT] = s.err_cke;
        end
        dci_pkg::REG_CMDCNT: begin
          next_s.apb.prdata[15:0] = s.cmd_cnt;
        end
        default: begin
          // four mode registers sit in one aligned window
          if ((apb_req.paddr[11:4] == dci_pkg::REG_MODE_BASE[11:4]) && (apb_req.paddr[1:0] == 2'b00)) begin
            next_s.apb.prdata[dci_pkg::ADDR_W-1:0] = s.mode[apb_req.paddr[3:2]];
          end else begin
            next_s.apb.pslverr = 1'b1; // unmapped
          end
        end
      endcase
    end
    // ---- apb write commit at the completing access edge
    if (apb_req.psel && apb_req.penable && s.apb.pready && apb_req.pwrite && !s.apb.pslverr) begin
      if (apb_req.paddr == dci_pkg::REG_CONFIG) begin
        // unsupported latencies keep the old value
        if ((apb_req.pwdata[dci_pkg::CFG_CL_LSB +: 3] >= dci_pkg::CL_MIN)
            && (apb_req.pwdata[dci_pkg::CFG_CL_LSB +: 3] <= dci_pkg::CL_MAX)) begin
          next_s.cl = apb_req.pwdata[dci_pkg::CFG_CL_LSB +: 3];
        end
        if (apb_req.pwdata[dci_pkg::CFG_AL_LSB +: 3] <= dci_pkg::AL_MAX) begin
          next_s.al = apb_req.pwdata[dci_pkg::CFG_AL_LSB +: 3];
        end
        next_s.bl8 = apb_req.pwdata[dci_pkg::CFG_BL8_BIT];
        next_s.x16 = apb_req.pwdata[dci_pkg::CFG_X16_BIT];
      end else if (apb_req.paddr == dci_pkg::REG_STATUS) begin
        // write one to clear; a new error below overrides the clear
        if (apb_req.pwdata[dci_pkg::STAT_ERR_CLOSED_BIT]) begin
          next_s.err_closed = 1'b0;
        end
        if (apb_req.pwdata[dci_pkg::STAT_ERR_CKE_BIT]) begin
          next_s.err_cke = 1'b0;
        end
      end else if (apb_req.paddr == dci_pkg::REG_CMDCNT) begin
        next_s.cmd_cnt = '0;
      end else begin
        next_s.mode[apb_req.paddr[3:2]] = apb_req.pwdata[dci_pkg::ADDR_W-1:0];
      end
    end
    // ---- command side
    if (cmd_live && (cmd_code != dci_pkg::CMD_NOP) && !cmd_code[3]) begin
      next_s.cmd_cnt = s.cmd_cnt + 16'h0001;
    end
    if (is_mrs) begin
      next_s.mode[cmd_pins.bank_sel[1:0]] = cmd_pins.addr;
    end
    if ((is_rd || is_wr) && !row_open[cmd_pins.bank_sel]) begin
      next_s.err_closed = 1'b1;
    end
    if (col_ok) begin
      next_s.bst_act = 1'b1;
      next_s.bst_wr = is_wr;
      // writes sample one cycle before reads would drive
      next_s.bst_wait = rl_m1;
      next_s.bst_beat = 2'h0;
      next_s.bst_bank = cmd_pins.bank_sel;
      next_s.bst_col = cmd_pins.addr[9:0];
      next_s.bst_ap = cmd_pins.addr[10];
    end else if (s.bst_act && (s.bst_wait != 4'h0)) begin
      next_s.bst_wait = s.bst_wait - 4'h1;
    end
    // ---- read output, two words per clock from a four-word fetch
    next_s.rd.rd_valid = 1'b0;
    if (beat_now) begin
      next_s.bst_beat = s.bst_beat + 2'h1;
      if (bst_end) begin
        next_s.bst_act = 1'b0;
      end
      if (!s.bst_wr) begin
        // data drivers only run once the loop has locked
        next_s.rd.rd_valid = s.dll_locked;
        if (!s.bst_beat[0]) begin
          next_s.rd.rd_word_rise = mem[widx[0]];
          next_s.rd.rd_word_fall = mem[widx[1]];
          next_s.pf = {mem[widx[3]], mem[widx[2]]};
        end else begin
          next_s.rd.rd_word_rise = s.pf[dci_pkg::DQ_W-1:0];
          next_s.rd.rd_word_fall = s.pf[2*dci_pkg::DQ_W-1:dci_pkg::DQ_W];
        end
      end
    end
    // gating dropped mid-burst: abandon it and flag the controller
    if (s.bst_act && !cmd_pins.cke) begin
      next_s.bst_act = 1'b0;
      next_s.err_cke = 1'b1;
    end
    // ---- power states
    case (s.pwr)
      dci_pkg::PWR_ACTIVE: begin
        if (!cmd_pins.cke) begin
          if (all_idle && is_ref && !s.bst_act) begin
            next_s.pwr = dci_pkg::PWR_SELF_REF;
          end else if (all_idle) begin
            next_s.pwr = dci_pkg::PWR_PRE_PD;
          end else begin
            next_s.pwr = dci_pkg::PWR_ACT_PD;
          end
        end
      end
      dci_pkg::PWR_ACT_PD, dci_pkg::PWR_PRE_PD: begin
        if (cmd_pins.cke) begin
          next_s.pwr = dci_pkg::PWR_ACTIVE;
        end
      end
      dci_pkg::PWR_SELF_REF: begin
        // exit needs no other input; clocks may have just restarted
        if (cmd_pins.cke) begin
          next_s.pwr = dci_pkg::PWR_ACTIVE;
        end
      end
      default: begin
        next_s.pwr = dci_pkg::PWR_ACTIVE;
      end
    endcase
    // ---- delay-locked loop: stops in self refresh, relocks on exit
    if (s.pwr == dci_pkg::PWR_SELF_REF) begin
      next_s.dll_cnt = 5'h00;
      next_s.dll_locked = 1'b0;
    end else if (s.dll_cnt != dci_pkg::DLL_LOCK_CYC) begin
      next_s.dll_cnt = s.dll_cnt + 5'h01;
    end else begin
      next_s.dll_locked = 1'b1;
    end
    // ---- termination input stays alive in power-down, not in self refresh
    next_s.odt_active = termination_enable && (s.pwr != dci_pkg::PWR_SELF_REF);
  end

  // ==========================================================
  // state register, rising edge of the true clock
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
      s.cl <= dci_pkg::CL_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs, all straight from the state register
  assign apb_rsp = s.apb;
  assign rd_data = s.rd;
  assign dll_locked = s.dll_locked;
  assign odt_active = s.odt_active;

endmodule

/* File: rtl/dci_pkg.sv */
// shared types, register map and constants for the sdram command interface
package dci_pkg;

  // ==========================================================
  // geometry
  localparam int unsigned NBANK = 8; // independent internal banks
  localparam int unsigned ADDR_W = 15; // address pins, row width of the x8 part
  localparam int unsigned DQ_W = 8; // one data word
  localparam int unsigned MEM_DEPTH = 256; // 8 banks x 32 columns kept in the model array

  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 100; // 10 mhz system clock
  localparam int unsigned DLL_LOCK_NS = 2000; // delay-locked loop settling time
  localparam logic [4:0] DLL_LOCK_CYC = 5'((DLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================
  // latency and burst settings
  localparam logic [2:0] CL_MIN = 3'h3; // shortest read column latency
  localparam logic [2:0] CL_MAX = 3'h7; // longest read column latency
  localparam logic [2:0] AL_MAX = 3'h6; // longest posted extra latency
  localparam logic [2:0] CL_RESET = 3'h3; // read column latency after reset

  // ==========================================================
  // apb register map (byte addresses)
  localparam logic [11:0] REG_CONFIG = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_CMDCNT = 12'h008;
  localparam logic [11:0] REG_MODE_BASE = 12'h010; // four mode registers, one word each

  // config fields
  localparam int unsigned CFG_CL_LSB = 0;
  localparam int unsigned CFG_AL_LSB = 4;
  localparam int unsigned CFG_BL8_BIT = 8;
  localparam int unsigned CFG_X16_BIT = 9;

  // status fields
  localparam int unsigned STAT_OPEN_LSB = 0;
  localparam int unsigned STAT_PWR_LSB = 8;
  localparam int unsigned STAT_DLL_BIT = 10;
  localparam int unsigned STAT_ERR_CLOSED_BIT = 16;
  localparam int unsigned STAT_ERR_CKE_BIT = 17;

  // ==========================================================
  // command codes: {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    CMD_MRS = 4'b0000, // mode_reg_set_cmd / ext_mode_reg_set_cmd
    CMD_REF = 4'b0001,
    CMD_PRE = 4'b0010,
    CMD_ACT = 4'b0011,
    CMD_WR = 4'b0100,
    CMD_RD = 4'b0101,
    CMD_NOP = 4'b0111
  } dci_cmd_t;

  // power states
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_ACT_PD = 2'b01,
    PWR_PRE_PD = 2'b10,
    PWR_SELF_REF = 2'b11
  } dci_pwr_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } dci_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dci_apb_rsp_t;

  typedef struct packed {
    logic cke; // clock gating input
    logic cs_n; // rank select, active low
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] bank_sel;
    logic [ADDR_W-1:0] addr;
  } dci_cmd_pins_t;

  typedef struct packed {
    logic [DQ_W-1:0] wr_word_rise; // word on the rising crossing
    logic [DQ_W-1:0] wr_word_fall; // word on the falling crossing
    logic [1:0] write_mask; // bit 0 rise word, bit 1 fall word
  } dci_wr_data_t;

  typedef struct packed {
    logic rd_valid;
    logic [DQ_W-1:0] rd_word_rise;
    logic [DQ_W-1:0] rd_word_fall;
  } dci_rd_data_t;

  // per-bank state
  typedef struct packed {
    logic open;
    logic [ADDR_W-1:0] row;
  } dci_bank_t;

  // state of the top module, except the data array
  typedef struct packed {
    dci_apb_rsp_t apb;
    dci_rd_data_t rd;
    logic [2:0] cl;
    logic [2:0] al;
    logic bl8;
    logic x16;
    logic [3:0][ADDR_W-1:0] mode;
    dci_pwr_t pwr;
    logic [4:0] dll_cnt;
    logic dll_locked;
    logic odt_active;
    logic err_closed;
    logic err_cke;
    logic [15:0] cmd_cnt;
    logic bst_act;
    logic bst_wr;
    logic [3:0] bst_wait;
    logic [1:0] bst_beat;
    logic [2:0] bst_bank;
    logic [9:0] bst_col;
    logic bst_ap;
    logic [2*DQ_W-1:0] pf;
  } dci_state_t;

endpackage

/* File: rtl/dci_bank.sv */
// one bank: open flag and registered row
module dci_bank (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic act_hit, // activate aimed at this bank
  input wire logic pre_hit, // precharge aimed at this bank
  input wire logic [dci_pkg::ADDR_W-1:0] row_in,
  output logic row_open,
  output logic [dci_pkg::ADDR_W-1:0] open_row
);

  dci_pkg::dci_bank_t s; // bank state
  dci_pkg::dci_bank_t next_s; // next bank state

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    if (act_hit) begin
      next_s.open = 1'b1;
      next_s.row = row_in;
    end else if (pre_hit) begin
      next_s.open = 1'b0;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign row_open = s.open;
  assign open_row = s.row;

endmodule

/* File: verification/dci_cmd_if_sva.sv */
// port assertions for the sdram command interface
module dci_cmd_if_sva (
  input wire logic clock,
  input wire logic sys_rst,
  input wire dci_pkg::dci_apb_req_t apb_req,
  input wire dci_pkg::dci_apb_rsp_t apb_rsp,
  input wire dci_pkg::dci_cmd_pins_t cmd_pins,
  input wire logic termination_enable,
  input wire dci_pkg::dci_wr_data_t wr_data,
  input wire dci_pkg::dci_rd_data_t rd_data,
  input wire logic dll_locked,
  input wire logic odt_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // helpers
  logic rd_cmd; // read code with gating high
  assign rd_cmd = cmd_pins.cke && ({cmd_pins.cs_n, cmd_pins.ras_n, cmd_pins.cas_n, cmd_pins.we_n} == dci_pkg::CMD_RD);
  // ==========================================================
  // apb side
  a_pready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready held longer than one cycle");
  a_pready_setup: assert property (apb_rsp.pready |-> $past(apb_req.psel && !apb_req.penable) && apb_req.penable)
    else $error("pready without a setup cycle");
  a_err_quiet: assert property (apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0000_0000)
    else $error("error response badly formed");
  // ==========================================================
  // read beats and termination
  a_rd_min_lat: assert property (rd_cmd && !rd_data.rd_valid |=> !rd_data.rd_valid [*3])
    else $error("read data earlier than three cycles");
  a_rd_pairs: assert property ($rose(rd_data.rd_valid) && cmd_pins.cke |=> rd_data.rd_valid)
    else $error("burst shorter than two beats");
  a_rd_cap: assert property (rd_data.rd_valid [*4] |=> !rd_data.rd_valid)
    else $error("burst longer than four beats");
  a_rd_locked: assert property (rd_data.rd_valid |-> dll_locked)
    else $error("read beat before lock");
  a_odt_follow: assert property ($past(cmd_pins.cke) && $past(cmd_pins.cke, 2)
    |-> odt_active == $past(termination_enable))
    else $error("termination does not follow its input");
  a_pd_quiet: assert property (!cmd_pins.cke && !$past(cmd_pins.cke) |-> !rd_data.rd_valid)
    else $error("read beat while gated");
endmodule

/* File: verification/dci_ctrl_model.sv */
// controller model: command pins and write data
module dci_ctrl_model (
  input wire logic clock,
  output dci_pkg::dci_cmd_pins_t pins,
  output dci_pkg::dci_wr_data_t wd
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // idle: gating high, this rank selected, nop
  initial begin
    pins = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 3'h0, 15'h0000};
    wd = '0;
  end
  // one command cycle; gating untouched so accesses keep it high
  task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a);
    @(posedge clock);
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= c;
    pins.bank_sel <= b;
    pins.addr <= a;
    @(posedge clock);
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= dci_pkg::CMD_NOP;
    pins.addr <= ~a; // stale address must not be reused
  endtask
  // gating change together with a command code
  task automatic pwr(input logic ck, input logic [3:0] c);
    @(posedge clock);
    pins.cke <= ck;
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= c;
    @(posedge clock);
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= dci_pkg::CMD_NOP;
  endtask
  // write burst: words driven from cycle rl-1 after the command edge
  task automatic wr(input logic [2:0] b, input logic [9:0] col, input int rl, input int nw,
                    input logic [7:0] base, input logic [1:0] m0);
    cmd(dci_pkg::CMD_WR, b, {5'h00, col});
    repeat (rl - 1) @(posedge clock);
    for (int i = 0; i < nw / 2; i++) begin
      wd <= '{base + 8'(2 * i), base + 8'(2 * i + 1), i == 0 ? m0 : 2'h0};
      @(posedge clock);
    end
    wd <= ~wd; // released lines carry garbage
  endtask
endmodule

/* File: verification/tb_dci_cmd_if.sv */
// self-checking testbench for the sdram command interface
module tb_dci_cmd_if;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock;
  logic sys_rst;
  logic termination_enable;
  dci_pkg::dci_apb_req_t req;
  dci_pkg::dci_apb_rsp_t rsp;
  dci_pkg::dci_cmd_pins_t pins;
  dci_pkg::dci_wr_data_t wd;
  dci_pkg::dci_rd_data_t rd;
  logic dll_locked;
  logic odt_active;
  int error_cnt = 0;
  int n_checks = 0;
  logic [7:0] mem [0:255]; // mirror of written words
  logic [31:0] rv; // last apb read data
  logic er; // last apb error flag
  dci_cmd_if dut (.clock(clock), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp), .cmd_pins(pins),
    .termination_enable(termination_enable), .wr_data(wd), .rd_data(rd), .dll_locked(dll_locked),
    .odt_active(odt_active));
  dci_ctrl_model ctrl (.clock(clock), .pins(pins), .wd(wd));
  // ==========================================================
  // clock and helpers
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    req.penable <= 1'b1;
    do @(posedge clock); while (rsp.pready !== 1'b1);
    rv = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  // word index with wrap inside the burst block
  function automatic int idx(input logic [2:0] b, input logic [9:0] col, input int i, input int nw);
    return b * 32 + ((col & (32 - nw)) | ((col + i) & (nw - 1)));
  endfunction
  task automatic wrb(input logic [2:0] b, input logic [9:0] col, input int rl, input int nw,
                     input logic [7:0] base, input logic [1:0] m0);
    for (int i = 0; i < nw; i++)
      if (!(i < 2 && m0[i])) mem[idx(b, col, i, nw)] = base + 8'(i);
    ctrl.wr(b, col, rl, nw, base, m0);
  endtask
  // read burst: latency, beats and words judged against the mirror
  task automatic rdb(input logic [2:0] b, input logic [9:0] col, input int rl, input int nw, input logic ap);
    int n;
    n = 0;
    ctrl.cmd(dci_pkg::CMD_RD, b, {4'h0, ap, col});
    @(negedge clock);
    while (rd.rd_valid !== 1'b1 && n < 20) begin
      n++;
      @(negedge clock);
    end
    chk(n, rl);
    for (int j = 0; j < nw; j += 2) begin
      chk(rd.rd_valid, 1'b1);
      chk(rd.rd_word_rise, mem[idx(b, col, j, nw)]);
      chk(rd.rd_word_fall, mem[idx(b, col, j + 1, nw)]);
      @(negedge clock);
    end
    chk(rd.rd_valid, 1'b0);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    apb(1'b0, dci_pkg::REG_CONFIG, 32'h0000_0000);
    chk(rv, 32'h0000_0003);
    apb(1'b0, 12'h0fc, 32'h0000_0000);
    chk(er, 1'b1);
    chk(rv, 32'h0000_0000);
    repeat (25) @(posedge clock); // lock wait before traffic
    chk(dll_locked, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_rw();
    ctrl.cmd(dci_pkg::CMD_ACT, 3'h2, 15'h7abc);
    ctrl.cmd(dci_pkg::CMD_ACT, 3'h3, 15'h1234);
    apb(1'b0, dci_pkg::REG_STATUS, 32'h0000_0000);
    chk(rv, 32'h0000_040c);
    wrb(3'h2, 10'h000, 3, 4, 8'h10, 2'h0);
    rdb(3'h2, 10'h002, 3, 4, 1'b0);
    wrb(3'h2, 10'h000, 3, 4, 8'h40, 2'h2);
    rdb(3'h2, 10'h000, 3, 4, 1'b0);
    $display("test read write done");
  endtask
  task automatic t_lat();
    for (int c = 3; c <= 7; c++) begin
      apb(1'b1, dci_pkg::REG_CONFIG, 32'(c));
      rdb(3'h2, 10'h001, c, 4, 1'b0);
    end
    apb(1'b1, dci_pkg::REG_CONFIG, 32'h0000_0167);
    wrb(3'h3, 10'h004, 13, 8, 8'h80, 2'h0);
    rdb(3'h3, 10'h006, 13, 8, 1'b0);
    apb(1'b1, dci_pkg::REG_CONFIG, 32'h0000_0272);
    apb(1'b0, dci_pkg::REG_CONFIG, 32'h0000_0000);
    chk(rv, 32'h0000_0267);
    apb(1'b1, dci_pkg::REG_CONFIG, 32'h0000_0003);
    $display("test latency done");
  endtask
  task automatic t_cmd();
    ctrl.cmd(dci_pkg::CMD_RD, 3'h5, 15'h0000);
    apb(1'b0, dci_pkg::REG_STATUS, 32'h0000_0000);
    chk(rv, 32'h0001_040c);
    apb(1'b1, dci_pkg::REG_STATUS, 32'h0001_0000);
    ctrl.cmd(4'hb, 3'h6, 15'h0000);
    apb(1'b0, dci_pkg::REG_STATUS, 32'h0000_0000);
    chk(rv, 32'h0000_040c);
    ctrl.cmd(dci_pkg::CMD_PRE, 3'h2, 15'h0000);
    rdb(3'h3, 10'h004, 3, 4, 1'b1);
    apb(1'b0, dci_pkg::REG_STATUS, 32'h0000_0000);
    chk(rv, 32'h0000_0400);
    ctrl.cmd(dci_pkg::CMD_ACT, 3'h2, 15'h0001);
    ctrl.cmd(dci_pkg::CMD_ACT, 3'h3, 15'h0002);
    ctrl.cmd(dci_pkg::CMD_PRE, 3'h0, 15'h0400);
    ctrl.cmd(dci_pkg::CMD_MRS, 3'h1, 15'h0123);
    apb(1'b0, dci_pkg::REG_STATUS, 32'h0000_0000);
    chk(rv, 32'h0000_0400);
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk(rv, 32'h0000_0123);
    apb(1'b1, dci_pkg::REG_CMDCNT, 32'h0000_0000);
    ctrl.cmd(dci_pkg::CMD_PRE, 3'h0, 15'h0400);
    apb(1'b0, dci_pkg::REG_CMDCNT, 32'h0000_0000);
    chk(rv, 32'h0000_0001);
    $display("test commands done");
  endtask
  task automatic t_pwr();
    @(posedge clock);
    termination_enable <= 1'b1;
    ctrl.cmd(dci_pkg::CMD_ACT, 3'h1, 15'h0000);
    ctrl.pwr(1'b0, dci_pkg::CMD_NOP);
    apb(1'b0, dci_pkg::REG_STATUS, 32'h0000_0000);
    chk(rv & 32'h0000_03ff, 32'h0000_0102);
    chk(odt_active, 1'b1);
    ctrl.pwr(1'b1, dci_pkg::CMD_NOP);
    ctrl.cmd(dci_pkg::CMD_PRE, 3'h0, 15'h0400);
    ctrl.pwr(1'b0, dci_pkg::CMD_NOP);
    apb(1'b0, dci_pkg::REG_STATUS, 32'h0000_0000);
    chk(rv & 32'h0000_03ff, 32'h0000_0200);
    ctrl.pwr(1'b1, dci_pkg::CMD_NOP);
    ctrl.pwr(1'b0, dci_pkg::CMD_REF);
    ctrl.cmd(dci_pkg::CMD_ACT, 3'h4, 15'h0000);
    apb(1'b0, dci_pkg::REG_STATUS, 32'h0000_0000);
    chk(rv & 32'h0000_03ff, 32'h0000_0300);
    chk(odt_active, 1'b0);
    ctrl.pwr(1'b1, dci_pkg::CMD_NOP);
    apb(1'b0, dci_pkg::REG_STATUS, 32'h0000_0000);
    chk(rv & 32'h0000_03ff, 32'h0000_0000);
    termination_enable <= 1'b0;
    $display("test power done");
  endtask
  // ==========================================================
  // verdict, main sequence and watchdog
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    sys_rst = 1'b1;
    termination_enable = 1'b0;
    req = '0;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_rw();
    t_lat();
    t_cmd();
    t_pwr();
    tally_and_finish();
  end
  initial begin
    #2000000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
bind dci_cmd_if dci_cmd_if_sva u_sva (.clock(clock), .sys_rst(sys_rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .cmd_pins(cmd_pins), .termination_enable(termination_enable), .wr_data(wr_data), .rd_data(rd_data),
  .dll_locked(dll_locked), .odt_active(odt_active));
